// File: common/egress_defs.vh
// register offsets, fields, reset values and timing for the egress block
`ifndef EGRESS_DEFS_VH
`define EGRESS_DEFS_VH
`define A_MODE 8'h00
`define A_OPERATE 8'h04
`define A_SRESET 8'h08
`define A_CFG 8'h0C
`define A_BUCKET 8'h10
`define A_STATUS 8'h14
`define A_MCAST_LO 8'h40
`define A_MCAST_HI 8'h7C
`define CFG_FILL_EN 0
`define CFG_FILL_IDLE 1
`define CFG_DEPTH4 2
`define CFG_XLATE_EN 3
`define CFG_CONN_TBL 4
`define CFG_LINK_TBL 5
`define CFG_RESET 6'h00
`define BKT_RESET 16'h0810
`define RESET_NS 8000
`define CLK_NS 40
`define RESET_CYC 8'hC8
`define SLOT_CYC 7'h40
`define CELL_BYTES 6'h35
`define HEC_IDX 6'h04
`define FILL_PAYLOAD 8'h6A
`define IDLE_HDR 32'h00000001
`define UNASSIGNED_HDR 32'h00000000
`define IDLE_OCT 8'h01
`define UNASSIGNED_OCT 8'h00
`endif

// File: src/egress_cell_path.v
// egress cell path: slot scheduling, insertion, translation, phy fifo, mode
`timescale 1ns/1ps
`include "egress_defs.vh"
`default_nettype none
module egress_cell_path (
    input wire CLK_IN,
    input wire RST_B_IN,
    input wire [7:0] ADDR_IN,
    input wire [31:0] WDATA_IN,
    input wire WR_IN,
    input wire RD_IN,
    output reg [31:0] RDATA_OUT,
    input wire SW_CELL_AVAIL_IN,
    input wire SW_FIFO_FULL_IN,
    input wire [31:0] SW_HDR_IN,
    input wire [15:0] SW_ID_IN,
    input wire SW_MCAST_IN,
    input wire SW_EFCI_IN,
    input wire [7:0] SW_BYTE_IN,
    output wire SW_POP_OUT,
    output wire SW_BYTE_RD_OUT,
    output wire SW_TX_CLAV_OUT,
    input wire [2:0] INS_REQ_IN,
    input wire [31:0] INS_HDR_IN,
    input wire [15:0] INS_ID_IN,
    input wire [7:0] INS_BYTE_IN,
    output reg [2:0] INS_GRANT_OUT,
    output wire INS_BYTE_RD_OUT,
    output reg [15:0] CTX_ECI_OUT,
    output wire CTX_RD_OUT,
    input wire CTX_VPC_IN,
    input wire [27:0] CTX_XLATE_IN,
    output wire MEM_WB_OUT,
    output wire RX_ENB_B_OUT,
    output reg [7:0] TX_DATA_OUT,
    output reg TX_PRTY_OUT,
    output reg TX_SOC_OUT,
    output reg TX_ENB_B_OUT,
    input wire TX_CLAV_IN,
    output reg CNT_CONN_INC_OUT,
    output reg CNT_LINK_INC_OUT,
    output reg [1:0] CNT_SEL_OUT,
    output reg [15:0] CNT_ECI_OUT,
    output wire OPERATE_OUT,
    output wire RESET_BUSY_OUT
);
    localparam S_IDLE = 3'h0;
    localparam S_ID = 3'h1;
    localparam S_HDR = 3'h2;
    localparam S_BYTES = 3'h3;
    localparam S_DONE = 3'h4;

    reg operate;
    reg [7:0] rst_cnt;
    reg srst_pend;
    reg [5:0] cfg;
    reg [15:0] bucket_cfg;
    reg [7:0] bucket_lvl;
    reg [15:0] mcast_tbl [0:15];
    reg [2:0] state;
    reg [6:0] slot_cnt;
    reg from_ins;
    reg [31:0] hdr;
    reg efci;
    reg [5:0] wr_idx;
    reg [7:0] cell_mem [0:211];
    reg [15:0] meta_eci [0:3];
    reg [1:0] meta_sel [0:3];
    reg [1:0] wptr;
    reg [1:0] rptr;
    reg [2:0] count;
    reg tx_busy;
    reg tx_fill;
    reg [5:0] tx_idx;
    reg [1:0] tx_ptr;
    reg skip_next;
    reg [7:0] fill_byte;
    reg [7:0] next_byte;
    reg [31:0] next_hdr;
    reg [31:0] rd_word;
    integer i;

    wire soft_go = srst_pend && (state == S_IDLE);
    wire ireset = !RST_B_IN || soft_go;
    wire busy = (rst_cnt != 8'h00);
    wire cfg_wr = WR_IN && !busy && !operate;
    wire [2:0] depth = cfg[`CFG_DEPTH4] ? 3'h4 : 3'h2;
    wire fifo_full = (count == depth);
    wire slot_start = (slot_cnt == 7'h00);
    wire bkt_ok = (bucket_lvl <= bucket_cfg[15:8]);
    wire ins_any = (INS_REQ_IN != 3'h0);
    wire ins_go = operate && slot_start && !skip_next && !fifo_full &&
        ins_any && bkt_ok;
    wire sw_go = operate && slot_start && !skip_next && !fifo_full &&
        !ins_go && SW_CELL_AVAIL_IN;
    wire [31:0] in_hdr = from_ins ? INS_HDR_IN : SW_HDR_IN;
    wire in_oam = (hdr[3:2] == 2'b10) ||
        (hdr[19:4] == 16'h0003) || (hdr[19:4] == 16'h0004);
    wire tx_start = !tx_busy && TX_CLAV_IN && operate &&
        ((count != 3'h0) || cfg[`CFG_FILL_EN]);
    wire tx_take = tx_start && (count != 3'h0);
    wire wr_done = (state == S_DONE);
    wire [7:0] wbase = {6'h00, wptr} * {2'h0, `CELL_BYTES};
    wire [7:0] tbase = {6'h00, tx_ptr} * {2'h0, `CELL_BYTES};
    wire [7:0] tx_oct = tx_fill ? fill_byte : cell_mem[tbase + {2'h0, tx_idx}];

    assign OPERATE_OUT = operate;
    assign RESET_BUSY_OUT = busy || srst_pend;
    assign SW_POP_OUT = sw_go;
    assign SW_TX_CLAV_OUT = operate && !SW_FIFO_FULL_IN;
    assign RX_ENB_B_OUT = !operate;
    assign CTX_RD_OUT = operate && (state == S_ID);
    assign MEM_WB_OUT = operate && wr_done;
    assign SW_BYTE_RD_OUT = (state == S_BYTES) && !from_ins &&
        (wr_idx > `HEC_IDX);
    assign INS_BYTE_RD_OUT = (state == S_BYTES) && from_ins &&
        (wr_idx > `HEC_IDX);

    // header rewrite for translation and congestion marking
    always @* begin
        next_hdr = hdr;
        if (cfg[`CFG_XLATE_EN]) begin
            next_hdr[31:20] = CTX_XLATE_IN[27:16];
            if (!CTX_VPC_IN) begin
                next_hdr[19:4] = CTX_XLATE_IN[15:0];
            end
        end
        if (efci && (hdr[3:2] == 2'b00)) begin
            next_hdr[2] = 1'b1;
        end
    end

    // byte stored into the phy fifo at the write index
    always @* begin
        case (wr_idx)
            6'h00: next_byte = hdr[31:24];
            6'h01: next_byte = hdr[23:16];
            6'h02: next_byte = hdr[15:8];
            6'h03: next_byte = hdr[7:0];
            `HEC_IDX: next_byte = 8'h00;
            default: next_byte = from_ins ? INS_BYTE_IN : SW_BYTE_IN;
        endcase
    end

    // filler cell bytes, unassigned or idle
    always @* begin
        case (tx_idx)
            6'h00: fill_byte = 8'h00;
            6'h01: fill_byte = 8'h00;
            6'h02: fill_byte = 8'h00;
            6'h03: fill_byte = cfg[`CFG_FILL_IDLE] ? `IDLE_OCT :
                `UNASSIGNED_OCT;
            `HEC_IDX: fill_byte = 8'h00;
            default: fill_byte = `FILL_PAYLOAD;
        endcase
    end

    // reset sequencing and mode
    always @(posedge CLK_IN) begin
        if (ireset) begin
            rst_cnt <= `RESET_CYC;
            operate <= 1'b0;
            srst_pend <= 1'b0;
        end else begin
            if (busy) begin
                rst_cnt <= rst_cnt - 8'h01;
            end
            if (WR_IN && !busy && ADDR_IN == `A_SRESET) begin
                srst_pend <= 1'b1;
            end
            if (WR_IN && !busy && !srst_pend && ADDR_IN == `A_OPERATE) begin
                operate <= 1'b1;
            end
        end
    end

    // configuration registers
    always @(posedge CLK_IN) begin
        if (ireset) begin
            cfg <= `CFG_RESET;
            bucket_cfg <= `BKT_RESET;
        end else if (cfg_wr) begin
            if (ADDR_IN == `A_CFG) begin
                cfg <= WDATA_IN[5:0];
            end
            if (ADDR_IN == `A_BUCKET) begin
                bucket_cfg <= WDATA_IN[15:0];
            end
        end
    end

    // multicast translation table, setup-writable
    always @(posedge CLK_IN) begin
        if (ireset) begin
            for (i = 0; i < 16; i = i + 1) begin
                mcast_tbl[i] <= 16'h0000;
            end
        end else if (cfg_wr && ADDR_IN >= `A_MCAST_LO &&
                ADDR_IN <= `A_MCAST_HI) begin
            mcast_tbl[ADDR_IN[5:2]] <= WDATA_IN[15:0];
        end
    end

    // register read, data one cycle later
    always @* begin
        case (ADDR_IN)
            `A_MODE: rd_word = {30'h00000000, RESET_BUSY_OUT, operate};
            `A_CFG: rd_word = {26'h0000000, cfg};
            `A_BUCKET: rd_word = {16'h0000, bucket_cfg};
            `A_STATUS: rd_word = {21'h000000, count, bucket_lvl};
            default: rd_word = (ADDR_IN >= `A_MCAST_LO &&
                ADDR_IN <= `A_MCAST_HI) ?
                {16'h0000, mcast_tbl[ADDR_IN[5:2]]} : 32'h00000000;
        endcase
    end

    always @(posedge CLK_IN) begin
        if (!RST_B_IN) begin
            RDATA_OUT <= 32'h00000000;
        end else begin
            RDATA_OUT <= RD_IN ? rd_word : 32'h00000000;
        end
    end

    // slot timer, pacing bucket and slot skipping
    always @(posedge CLK_IN) begin
        if (ireset) begin
            slot_cnt <= 7'h00;
            bucket_lvl <= 8'h00;
            skip_next <= 1'b0;
            INS_GRANT_OUT <= 3'h0;
        end else begin
            slot_cnt <= (slot_cnt == `SLOT_CYC - 7'h01) ? 7'h00 :
                slot_cnt + 7'h01;
            INS_GRANT_OUT <= 3'h0;
            if (slot_start) begin
                skip_next <= fifo_full;
                if (ins_go) begin
                    bucket_lvl <= bucket_lvl + bucket_cfg[7:0];
                    INS_GRANT_OUT <= INS_REQ_IN & (~INS_REQ_IN + 3'h1);
                end else if (bucket_lvl != 8'h00) begin
                    bucket_lvl <= bucket_lvl - 8'h01;
                end
            end
        end
    end

    // cell processing state machine
    always @(posedge CLK_IN) begin
        if (ireset) begin
            state <= S_IDLE;
            from_ins <= 1'b0;
            hdr <= 32'h00000000;
            efci <= 1'b0;
            wr_idx <= 6'h00;
            CTX_ECI_OUT <= 16'h0000;
        end else begin
            case (state)
                S_IDLE: begin
                    if (ins_go || sw_go) begin
                        from_ins <= ins_go;
                        state <= S_ID;
                    end
                end
                S_ID: begin
                    hdr <= in_hdr;
                    efci <= !from_ins && SW_EFCI_IN;
                    if (!from_ins && SW_MCAST_IN) begin
                        CTX_ECI_OUT <= mcast_tbl[SW_ID_IN[3:0]];
                    end else begin
                        CTX_ECI_OUT <= from_ins ? INS_ID_IN : SW_ID_IN;
                    end
                    state <= S_HDR;
                end
                S_HDR: begin
                    hdr <= next_hdr;
                    wr_idx <= 6'h00;
                    state <= S_BYTES;
                end
                S_BYTES: begin
                    wr_idx <= wr_idx + 6'h01;
                    if (wr_idx == `CELL_BYTES - 6'h01) begin
                        state <= S_DONE;
                    end
                end
                S_DONE: begin
                    state <= S_IDLE;
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    // cell storage for the phy fifo
    always @(posedge CLK_IN) begin
        if (state == S_BYTES) begin
            cell_mem[wbase + {2'h0, wr_idx}] <= next_byte;
        end
        if (wr_done) begin
            meta_eci[wptr] <= CTX_ECI_OUT;
            meta_sel[wptr] <= {in_oam, hdr[0]};
        end
    end

    // fifo pointers and occupancy
    always @(posedge CLK_IN) begin
        if (ireset) begin
            wptr <= 2'h0;
            rptr <= 2'h0;
            count <= 3'h0;
        end else begin
            if (wr_done) begin
                wptr <= cfg[`CFG_DEPTH4] ? wptr + 2'h1 :
                    {1'b0, ~wptr[0]};
            end
            if (tx_take) begin
                rptr <= cfg[`CFG_DEPTH4] ? rptr + 2'h1 : {1'b0, ~rptr[0]};
            end
            if (wr_done && !tx_take) begin
                count <= count + 3'h1;
            end else if (tx_take && !wr_done) begin
                count <= count - 3'h1;
            end
        end
    end

    // utopia transmit on the core clock
    always @(posedge CLK_IN) begin
        if (ireset) begin
            tx_busy <= 1'b0;
            tx_fill <= 1'b0;
            tx_idx <= 6'h00;
            tx_ptr <= 2'h0;
            TX_DATA_OUT <= 8'h00;
            TX_PRTY_OUT <= 1'b1;
            TX_SOC_OUT <= 1'b0;
            TX_ENB_B_OUT <= 1'b1;
            CNT_CONN_INC_OUT <= 1'b0;
            CNT_LINK_INC_OUT <= 1'b0;
            CNT_SEL_OUT <= 2'h0;
            CNT_ECI_OUT <= 16'h0000;
        end else begin
            CNT_CONN_INC_OUT <= 1'b0;
            CNT_LINK_INC_OUT <= 1'b0;
            if (tx_start) begin
                tx_busy <= 1'b1;
                tx_fill <= !tx_take;
                tx_idx <= 6'h00;
                if (tx_take) begin
                    tx_ptr <= rptr;
                    CNT_CONN_INC_OUT <= cfg[`CFG_CONN_TBL];
                    CNT_LINK_INC_OUT <= cfg[`CFG_LINK_TBL];
                    CNT_SEL_OUT <= meta_sel[rptr];
                    CNT_ECI_OUT <= meta_eci[rptr];
                end
            end
            if (tx_busy) begin
                TX_ENB_B_OUT <= 1'b0;
                TX_SOC_OUT <= (tx_idx == 6'h00);
                TX_DATA_OUT <= tx_oct;
                TX_PRTY_OUT <= ~^tx_oct;
                tx_idx <= tx_idx + 6'h01;
                if (tx_idx == `CELL_BYTES - 6'h01) begin
                    tx_busy <= 1'b0;
                end
            end else begin
                TX_ENB_B_OUT <= 1'b1;
                TX_SOC_OUT <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// File: sim/egress_checker.sv
// port assertions for the egress cell path
`timescale 1ns/1ps
`default_nettype none
module egress_checker (
    input wire logic CLK_IN,
    input wire logic RST_B_IN,
    input wire logic SW_FIFO_FULL_IN,
    input wire logic SW_POP_OUT,
    input wire logic SW_TX_CLAV_OUT,
    input wire logic [2:0] INS_REQ_IN,
    input wire logic [2:0] INS_GRANT_OUT,
    input wire logic CTX_RD_OUT,
    input wire logic MEM_WB_OUT,
    input wire logic RX_ENB_B_OUT,
    input wire logic [7:0] TX_DATA_OUT,
    input wire logic TX_PRTY_OUT,
    input wire logic TX_SOC_OUT,
    input wire logic TX_ENB_B_OUT,
    input wire logic OPERATE_OUT,
    input wire logic RESET_BUSY_OUT
);
    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (!RST_B_IN);
    logic [8:0] busy_run;
    sequence cell_open;
        SW_POP_OUT ##1 CTX_RD_OUT;
    endsequence
    // consecutive busy cycles since release or soft reset
    always_ff @(posedge CLK_IN) begin
        if (!RST_B_IN || !RESET_BUSY_OUT)
            busy_run <= 9'h000;
        else if (busy_run != 9'h1FF)
            busy_run <= busy_run + 9'h001;
    end
    a_parity_odd: assert property (^{TX_DATA_OUT, TX_PRTY_OUT})
        else $error("transmit parity not odd");
    a_setup_quiet: assert property (!OPERATE_OUT |-> RX_ENB_B_OUT &&
        !SW_TX_CLAV_OUT && !SW_POP_OUT && INS_GRANT_OUT == 3'h0)
        else $error("traffic while in setup");
    a_setup_nomem: assert property (!OPERATE_OUT |->
        !CTX_RD_OUT && !MEM_WB_OUT) else $error("memory used in setup");
    a_operate_held: assert property ($fell(OPERATE_OUT) |-> RESET_BUSY_OUT)
        else $error("left operate without reset");
    a_clav_full: assert property (SW_FIFO_FULL_IN |-> !SW_TX_CLAV_OUT)
        else $error("cell available while fifo full");
    a_hec_zero: assert property (TX_SOC_OUT && !TX_ENB_B_OUT |->
        ##4 TX_DATA_OUT == 8'h00) else $error("fifth octet not zero");
    a_one_slot: assert property (SW_POP_OUT |=>
        (!SW_POP_OUT && INS_GRANT_OUT == 3'h0) [*8])
        else $error("second cell in one slot");
    a_cell_walk: assert property (SW_POP_OUT |-> cell_open ##55 MEM_WB_OUT)
        else $error("cell writeback out of place");
    a_grant_prio: assert property (INS_GRANT_OUT != 3'h0 |-> CTX_RD_OUT &&
        INS_GRANT_OUT == ($past(INS_REQ_IN) & (~$past(INS_REQ_IN) + 3'h1)))
        else $error("insertion grant not highest queue");
    a_reset_setup: assert property ($rose(RST_B_IN) |-> !OPERATE_OUT)
        else $error("not in setup after reset");
    a_reset_length: assert property ($fell(RESET_BUSY_OUT) |->
        busy_run >= 9'h0C7) else $error("reset count too short");
endmodule
bind egress_cell_path egress_checker chk_u (.CLK_IN(CLK_IN),
    .RST_B_IN(RST_B_IN), .SW_FIFO_FULL_IN(SW_FIFO_FULL_IN),
    .SW_POP_OUT(SW_POP_OUT), .SW_TX_CLAV_OUT(SW_TX_CLAV_OUT),
    .INS_REQ_IN(INS_REQ_IN), .INS_GRANT_OUT(INS_GRANT_OUT),
    .CTX_RD_OUT(CTX_RD_OUT), .MEM_WB_OUT(MEM_WB_OUT),
    .RX_ENB_B_OUT(RX_ENB_B_OUT), .TX_DATA_OUT(TX_DATA_OUT),
    .TX_PRTY_OUT(TX_PRTY_OUT), .TX_SOC_OUT(TX_SOC_OUT),
    .TX_ENB_B_OUT(TX_ENB_B_OUT), .OPERATE_OUT(OPERATE_OUT),
    .RESET_BUSY_OUT(RESET_BUSY_OUT));
`default_nettype wire

// File: sim/phy_tx_model.sv
// transmit phy model: flow control and capture of the first five octets
`timescale 1ns/1ps
`default_nettype none
module phy_tx_model (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic stall_in,
    input wire logic [7:0] data_in,
    input wire logic soc_in,
    input wire logic enb_b_in,
    output logic clav_out,
    output logic [39:0] head_out,
    output logic [7:0] cells_out
);
    logic [5:0] idx;
    // runs on the same core clock as the block's transmit side
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            clav_out <= 1'b0;
            idx <= 6'h00;
            cells_out <= 8'h00;
            head_out <= 40'h0;
        end else begin
            clav_out <= !stall_in;
            if (!enb_b_in) begin
                idx <= soc_in ? 6'h01 : idx + 6'h01;
                if (soc_in || idx < 6'h05)
                    head_out <= {head_out[31:0], data_in};
                if (!soc_in && idx == 6'h34)
                    cells_out <= cells_out + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// File: sim/tb_top.sv
// self-checking bench for the egress cell path
`timescale 1ns/1ps
`default_nettype none
`include "egress_defs.vh"
module tb_top;
    logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, stall = 1'b0;
    logic sw_avail = 1'b0, sw_full = 1'b0, mcast = 1'b1, efci = 1'b1;
    logic vpc = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, sw_hdr = 32'h12345670;
    logic [31:0] ins_hdr = 32'h00100030;
    logic [15:0] sw_id = 16'h0003, ins_id = 16'h0055;
    logic [2:0] ins_req = 3'h0;
    logic [27:0] xlate = 28'hABCDEF0;
    logic [31:0] rdata;
    logic [15:0] egress_connection_id, cnt_eci;
    logic [2:0] grant;
    logic [7:0] txd, cells, cells0;
    logic [1:0] sel;
    logic [39:0] head;
    logic pop, clav, ctx_rd, wb, rx_b, prty, soc, enb_b, phy_clav;
    logic c_inc, l_inc, operate, busy;
    int fails = 0, checked = 0, conn_n = 0, link_n = 0;
    egress_cell_path dut_u (.CLK_IN(clk), .RST_B_IN(rst_b),
        .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd),
        .RDATA_OUT(rdata), .SW_CELL_AVAIL_IN(sw_avail),
        .SW_FIFO_FULL_IN(sw_full), .SW_HDR_IN(sw_hdr), .SW_ID_IN(sw_id),
        .SW_MCAST_IN(mcast), .SW_EFCI_IN(efci), .SW_BYTE_IN(8'h5A),
        .SW_POP_OUT(pop), .SW_BYTE_RD_OUT(), .SW_TX_CLAV_OUT(clav),
        .INS_REQ_IN(ins_req), .INS_HDR_IN(ins_hdr), .INS_ID_IN(ins_id),
        .INS_BYTE_IN(8'hA5), .INS_GRANT_OUT(grant), .INS_BYTE_RD_OUT(),
        .CTX_ECI_OUT(egress_connection_id), .CTX_RD_OUT(ctx_rd), .CTX_VPC_IN(vpc),
        .CTX_XLATE_IN(xlate), .MEM_WB_OUT(wb), .RX_ENB_B_OUT(rx_b),
        .TX_DATA_OUT(txd), .TX_PRTY_OUT(prty), .TX_SOC_OUT(soc),
        .TX_ENB_B_OUT(enb_b), .TX_CLAV_IN(phy_clav),
        .CNT_CONN_INC_OUT(c_inc), .CNT_LINK_INC_OUT(l_inc),
        .CNT_SEL_OUT(sel), .CNT_ECI_OUT(cnt_eci), .OPERATE_OUT(operate),
        .RESET_BUSY_OUT(busy));
    phy_tx_model phy_u (.clk_in(clk), .rst_b_in(rst_b), .stall_in(stall),
        .data_in(txd), .soc_in(soc), .enb_b_in(enb_b), .clav_out(phy_clav),
        .head_out(head), .cells_out(cells));
    initial begin
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        if (c_inc)
            conn_n <= conn_n + 1;
        if (l_inc)
            link_n <= link_n + 1;
    end
    task automatic finish_test;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic hit(input int s);
        case (s)
            0: return pop === 1'b1;
            1: return (|grant) === 1'b1;
            2: return wb === 1'b1;
            3: return busy === 1'b0;
            default: return cells !== cells0;
        endcase
    endfunction
    task automatic wait_hi(input int s);
        for (int n = 0; n < 2000; n++) begin
            @(negedge clk);
            if (hit(s))
                return;
        end
        fails++;
        finish_test();
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(rdata, e);
    endtask
    task automatic s_reset;
        wr_reg(`A_CFG, 32'h3F);
        rd_chk(`A_MODE, 32'h2);
        wait_hi(3);
        rd_chk(`A_CFG, 32'h0);
        rd_chk(`A_BUCKET, {16'h0, `BKT_RESET});
        rd_chk(`A_MODE, 32'h0);
    endtask
    task automatic s_config;
        wr_reg(`A_CFG, 32'h38);
        wr_reg(`A_MCAST_LO + 8'h0C, 32'h0123);
        rd_chk(`A_CFG, 32'h38);
        rd_chk(`A_MCAST_LO + 8'h0C, 32'h0123);
        rd_chk(8'h30, 32'h0);
        @(posedge clk);
        sw_avail <= 1'b1;
        repeat (70) @(posedge clk);
        sw_avail <= 1'b0;
        chk({30'h0, clav, rx_b}, 32'h1);
    endtask
    task automatic s_switch;
        wr_reg(`A_OPERATE, 32'h1);
        rd_chk(`A_MODE, 32'h1);
        wr_reg(`A_CFG, 32'h0);
        rd_chk(`A_CFG, 32'h38);
        @(posedge clk);
        sw_full <= 1'b1;
        @(negedge clk);
        chk({31'h0, clav}, 32'h0);
        @(posedge clk);
        sw_full <= 1'b0;
        sw_avail <= 1'b1;
        @(negedge clk);
        chk({30'h0, clav, rx_b}, 32'h2);
        cells0 = cells;
        wait_hi(0);
        @(posedge clk);
        sw_avail <= 1'b0;
        wait_hi(2);
        chk({16'h0, egress_connection_id}, 32'h0123);
        wait_hi(4);
        chk(head[39:8], 32'hABCDEF04);
        chk({24'h0, head[7:0]}, 32'h0);
        chk({link_n[15:0], conn_n[15:0]}, 32'h00010001);
        chk({14'h0, sel, cnt_eci}, 32'h00000123);
    endtask
    task automatic s_insert;
        time t0;
        @(posedge clk);
        stall <= 1'b1;
        vpc <= 1'b1;
        efci <= 1'b0;
        ins_req <= 3'h6;
        wait_hi(1);
        t0 = $time;
        chk({29'h0, grant}, 32'h2);
        @(posedge clk);
        ins_req <= 3'h4;
        wait_hi(1);
        chk({29'h0, grant}, 32'h4);
        chk({31'h0, ($time - t0) >= 64'h5000}, 32'h1);
        @(posedge clk);
        ins_req <= 3'h0;
        cells0 = cells;
        stall <= 1'b0;
        wait_hi(4);
        chk(head[39:8], 32'hABC00030);
        chk({30'h0, sel}, 32'h2);
    endtask
    task automatic s_soft;
        @(posedge clk);
        sw_avail <= 1'b1;
        wait_hi(0);
        @(posedge clk);
        sw_avail <= 1'b0;
        wr_reg(`A_SRESET, 32'h1);
        wait_hi(2);
        chk({31'h0, operate}, 32'h1);
        wait_hi(3);
        rd_chk(`A_MODE, 32'h0);
        rd_chk(`A_CFG, 32'h0);
    endtask
    task automatic s_fill;
        int c0;
        wr_reg(`A_CFG, 32'h33);
        wr_reg(`A_OPERATE, 32'h1);
        c0 = conn_n + link_n;
        cells0 = cells;
        wait_hi(4);
        chk(head[39:8], `IDLE_HDR);
        chk({24'h0, head[7:0]}, 32'h0);
        chk(conn_n + link_n, c0);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        s_reset();
        s_config();
        s_switch();
        s_insert();
        s_soft();
        s_fill();
        finish_test();
    end
endmodule
`default_nettype wire
